// [rtl/swl_buf.sv]
`timescale 1ns/1ps
module swl_buf #(
  parameter int WIDTH = 11
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic ce, // clock enable
  input wire logic in_valid, // writer offers a word
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // a word waits
  input wire logic out_ready, // reader takes it
  output logic [WIDTH-1:0] out_data // oldest word
);
  logic [WIDTH-1:0] mem [2];
  logic wp;
  logic rp;
  logic [1:0] count;
  logic push;
  logic pop;
  logic [1:0] next_count;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rp];
  assign next_count = count + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 1'b0;
      rp <= 1'b0;
      count <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        mem[wp] <= in_data;
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      count <= next_count;
      in_ready <= next_count != 2'h2;
      out_valid <= next_count != 2'h0;
    end
  end
endmodule

// [rtl/swl_if.sv]
`timescale 1ns/1ps
interface swl_if;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic line;
  // pull-up at the master end: the line is low only while someone drives low
  assign line = ~((host_oe & ~host_out) | (dev_oe & ~dev_out));
  modport host (output host_out, output host_oe, input line);
  modport dev (output dev_out, output dev_oe, input line);
endinterface

// [rtl/swl_master.sv]
`timescale 1ns/1ps
module swl_master #(
  parameter int RST_CYC = swl_pkg::HOST_RST_CYC, // reset pulse length
  parameter int REC_CYC = swl_pkg::RECOVERY_CYC, // wait after reset release
  parameter int EE_CYC = swl_pkg::EE_WRITE_CYC, // eeprom_write_time
  parameter int HASH_CYC = swl_pkg::HASH_CYC // hash_compute_time
) (
  input wire logic CLOCK, // system clock
  input wire logic RST_N, // async reset, low
  input wire logic CE, // clock enable
  input wire logic REQ_VALID, // request offered
  output logic REQ_READY, // request buffer has room
  input wire logic [2:0] REQ_KIND, // swl_pkg::op_t code
  input wire logic [7:0] REQ_DATA, // byte to write
  output logic RESP_VALID, // one pulse per finished request
  output logic [7:0] RESP_DATA, // read byte or presence in bit 0
  output logic [7:0] CRC_ACC, // running crc over read bytes
  output logic BUSY, // a reset, write, read or wait request is running
  swl_if.host BUS // shared line
);
  localparam logic [19:0] RST_T = 20'(RST_CYC - 1);
  localparam logic [19:0] REC_T = 20'(REC_CYC - 1);
  localparam logic [19:0] PS_T = 20'(swl_pkg::PRES_SAMPLE_CYC);
  localparam logic [19:0] SLOT_T = 20'(swl_pkg::SLOT_CYC - 1);
  localparam logic [19:0] W1_T = 20'(swl_pkg::W1_LOW_CYC - 1);
  localparam logic [19:0] W0_T = 20'(swl_pkg::W0_LOW_CYC - 1);
  localparam logic [19:0] RS_T = 20'(swl_pkg::RD_SAMPLE_CYC);
  localparam logic [19:0] EE_T = 20'(EE_CYC - 1);
  localparam logic [19:0] HE_T = 20'(HASH_CYC + EE_CYC - 1);

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_RST = 5'h02,
    H_REC = 5'h04,
    H_SLOT = 5'h08,
    H_WAIT = 5'h10
  } host_t;

  host_t state;
  logic [10:0] head;
  logic head_valid;
  logic take;
  logic [2:0] kind;
  logic [7:0] sr;
  logic [2:0] bitn;
  logic [19:0] tc;
  logic [19:0] tgt;
  logic pres;
  logic [19:0] low_t;

  // the engine drains only when idle, so a slow line fills the buffer
  swl_buf #(.WIDTH(11)) u_buf (
    .clk(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .in_valid(REQ_VALID),
    .in_ready(REQ_READY),
    .in_data({REQ_KIND, REQ_DATA}),
    .out_valid(head_valid),
    .out_ready(state == H_IDLE),
    .out_data(head)
  );

  assign take = head_valid && state == H_IDLE;
  assign low_t = (kind == swl_pkg::OP_READ || sr[0]) ? W1_T : W0_T;
  assign BUS.host_out = 1'b0;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= H_IDLE;
      kind <= 3'h0;
      sr <= 8'h00;
      bitn <= 3'h0;
      tc <= 20'h00000;
      tgt <= 20'h00000;
      pres <= 1'b0;
      BUS.host_oe <= 1'b0;
      RESP_VALID <= 1'b0;
      RESP_DATA <= 8'h00;
      CRC_ACC <= swl_pkg::CRC_INIT;
      BUSY <= 1'b0;
    end else if (CE) begin
      RESP_VALID <= 1'b0;
      tc <= tc + 20'h00001;
      case (state)
        H_IDLE: begin
          BUS.host_oe <= 1'b0;
          tc <= 20'h00000;
          if (take) begin
            kind <= head[10:8];
            sr <= head[7:0];
            bitn <= 3'h0;
            BUSY <= 1'b1;
            case (head[10:8])
              swl_pkg::OP_RESET: begin
                state <= H_RST;
                BUS.host_oe <= 1'b1;
              end
              swl_pkg::OP_WRITE, swl_pkg::OP_READ: begin
                state <= H_SLOT;
                BUS.host_oe <= 1'b1;
              end
              swl_pkg::OP_WAIT_EE: begin
                state <= H_WAIT;
                tgt <= EE_T;
              end
              swl_pkg::OP_WAIT_HASH: begin
                state <= H_WAIT;
                tgt <= HE_T;
              end
              default: begin
                CRC_ACC <= swl_pkg::CRC_INIT;
                RESP_VALID <= 1'b1;
                RESP_DATA <= 8'h00;
                BUSY <= 1'b0;
              end
            endcase
          end
        end
        H_RST: begin
          if (tc == RST_T) begin
            BUS.host_oe <= 1'b0;
            tc <= 20'h00000;
            state <= H_REC;
          end
        end
        H_REC: begin
          if (tc == PS_T) begin
            pres <= ~BUS.line;
          end
          if (tc == REC_T) begin
            state <= H_IDLE;
            RESP_VALID <= 1'b1;
            RESP_DATA <= {7'h00, pres};
            BUSY <= 1'b0;
          end
        end
        H_SLOT: begin
          if (tc == low_t) begin
            BUS.host_oe <= 1'b0;
          end
          if (kind == swl_pkg::OP_READ && tc == RS_T) begin
            sr <= {BUS.line, sr[7:1]};
          end
          if (tc == SLOT_T) begin
            tc <= 20'h00000;
            bitn <= bitn + 3'h1;
            if (kind == swl_pkg::OP_WRITE) begin
              sr <= {1'b0, sr[7:1]};
            end
            if (bitn == 3'h7) begin
              state <= H_IDLE;
              RESP_VALID <= 1'b1;
              RESP_DATA <= sr;
              BUSY <= 1'b0;
              if (kind == swl_pkg::OP_READ) begin
                CRC_ACC <= swl_pkg::crc8_byte(CRC_ACC, sr);
              end
            end else begin
              BUS.host_oe <= 1'b1;
            end
          end
        end
        H_WAIT: begin
          if (tc == tgt) begin
            state <= H_IDLE;
            RESP_VALID <= 1'b1;
            RESP_DATA <= 8'h00;
            BUSY <= 1'b0;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// [rtl/swl_pkg.sv]
package swl_pkg;
  localparam int CLK_NS = 25;

  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // bus timing, in ns
  localparam int SLOT_NS = 3500;
  localparam int W1_LOW_NS = 300;
  localparam int W0_LOW_NS = 3000;
  localparam int RD_SAMPLE_NS = 600;
  localparam int DEV_SAMPLE_NS = 750;
  localparam int DEV_HOLD_NS = 2250;
  localparam int LOW_RESET_NS = 5000;
  localparam int HOST_RST_NS = 10000;
  localparam int PRES_WAIT_NS = 750;
  localparam int PRES_LEN_NS = 3000;
  localparam int PRES_SAMPLE_NS = 2000;
  localparam int RECOVERY_NS = 10000;
  localparam int EE_WRITE_NS = 10000000;
  localparam int HASH_NS = 2000000;

  localparam int SLOT_CYC = cyc_up(SLOT_NS);
  localparam int W1_LOW_CYC = cyc_up(W1_LOW_NS);
  localparam int W0_LOW_CYC = cyc_up(W0_LOW_NS);
  localparam int RD_SAMPLE_CYC = cyc_up(RD_SAMPLE_NS);
  localparam int DEV_SAMPLE_CYC = cyc_up(DEV_SAMPLE_NS);
  localparam int DEV_HOLD_CYC = cyc_up(DEV_HOLD_NS);
  localparam int LOW_RESET_CYC = cyc_up(LOW_RESET_NS);
  localparam int HOST_RST_CYC = cyc_up(HOST_RST_NS);
  localparam int PRES_WAIT_CYC = cyc_up(PRES_WAIT_NS);
  localparam int PRES_LEN_CYC = cyc_up(PRES_LEN_NS);
  localparam int PRES_SAMPLE_CYC = cyc_up(PRES_SAMPLE_NS);
  localparam int RECOVERY_CYC = cyc_up(RECOVERY_NS);
  localparam int EE_WRITE_CYC = cyc_up(EE_WRITE_NS);
  localparam int HASH_CYC = cyc_up(HASH_NS);

  // node-address and function commands
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SKIP = 8'hCC;
  localparam logic [7:0] CMD_WR_CHAL = 8'h0C;
  localparam logic [7:0] CMD_CLEAR = 8'h5A;
  localparam logic [7:0] CMD_NEXT = 8'h30;
  localparam logic [7:0] CMD_NEXT_ID = 8'h33;
  localparam logic [7:0] CMD_LOCK = 8'h60;
  localparam logic [7:0] CMD_READ_STAT = 8'h69;

  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam logic [63:0] SECRET_RST = 64'h0000_0000_0000_0000;
  localparam logic LOCK_RST = 1'b0;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_WRITE = 3'h1,
    OP_READ = 3'h2,
    OP_WAIT_EE = 3'h3,
    OP_WAIT_HASH = 3'h4,
    OP_CRC_CLR = 3'h5
  } op_t;

  // lsb-first byte through x^8+x^5+x^4+1, reflected form
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// [rtl/swl_slave.sv]
`timescale 1ns/1ps
module swl_slave #(
  parameter int EE_CYC = swl_pkg::EE_WRITE_CYC, // eeprom_write_time in cycles
  parameter int HASH_CYC = swl_pkg::HASH_CYC, // hash_compute_time in cycles
  parameter logic [7:0] FAMILY = 8'hA5, // arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001 // arbitrary value
) (
  input wire logic CLOCK, // system clock
  input wire logic RST_N, // async reset, low
  input wire logic CE, // clock enable
  swl_if.dev BUS, // shared line
  output logic [63:0] SECRET, // stored secret
  output logic LOCKED, // secret-lock bit
  output logic BUSY, // hash or eeprom write running
  output logic SELECTED // addressed in this transaction
);
  function automatic logic [7:0] crc_over(input logic [63:0] w, input int n);
    logic [7:0] c;
    c = swl_pkg::CRC_INIT;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        c = swl_pkg::crc8_byte(c, w[8*i +: 8]);
      end
    end
    return c;
  endfunction

  // stand-in mixer; the true message block layout is not public
  function automatic logic [63:0] mix(input logic [63:0] s, input logic [63:0] id,
                                      input logic [63:0] c);
    logic [63:0] x;
    x = s ^ {c[31:0], c[63:32]} ^ id;
    for (int i = 0; i < 6; i++) begin
      x = {x[50:0], x[63:51]} ^ (x & {x[62:0], x[63]}) ^ c ^ {s[7:0], s[63:8]};
    end
    return x;
  endfunction

  localparam logic [55:0] ID_BODY = {SERIAL, FAMILY};
  localparam logic [63:0] NODE_ID = {crc_over({8'h00, ID_BODY}, 7), ID_BODY};
  localparam logic [11:0] CNT_MAX = 12'hFFF;
  localparam logic [11:0] SAMPLE_C = 12'(swl_pkg::DEV_SAMPLE_CYC);
  localparam logic [11:0] HOLD_C = 12'(swl_pkg::DEV_HOLD_CYC);
  localparam logic [11:0] RST_C = 12'(swl_pkg::LOW_RESET_CYC);
  localparam logic [11:0] PW_C = 12'(swl_pkg::PRES_WAIT_CYC);
  localparam logic [11:0] PE_C = 12'(swl_pkg::PRES_WAIT_CYC + swl_pkg::PRES_LEN_CYC);
  localparam logic [19:0] EE_T = 20'(EE_CYC - 1);
  localparam logic [19:0] HASH_T = 20'(HASH_CYC - 1);

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_PRES = 9'h002,
    S_ROM = 9'h004,
    S_IDTX = 9'h008,
    S_MATCH = 9'h010,
    S_FUNC = 9'h020,
    S_CHAL = 9'h040,
    S_ADDR = 9'h080,
    S_TX = 9'h100
  } link_t;

  typedef enum logic [2:0] {
    N_IDLE = 3'h1,
    N_HASH = 3'h2,
    N_WRITE = 3'h4
  } nv_t;

  link_t state;
  nv_t nv;
  logic dq_prev;
  logic [11:0] cnt;
  logic [11:0] pcnt;
  logic wait_rise;
  logic [79:0] sr;
  logic [6:0] bitcnt;
  logic mismatch;
  logic [7:0] cmd;
  logic [63:0] chal;
  logic [19:0] tmr;
  logic [63:0] pend;
  logic pend_lock;
  logic fall;
  logic rst_ev;
  logic slot_ev;
  logic last;
  logic cmd_ev;
  logic [7:0] nb;
  logic [63:0] nw;
  logic [63:0] status;
  logic [7:0] crc_ca;

  assign fall = dq_prev & ~BUS.line;
  assign rst_ev = ~BUS.line && cnt == RST_C;
  assign slot_ev = cnt == SAMPLE_C;
  assign nb = {BUS.line, sr[79:73]};
  assign nw = {BUS.line, sr[79:17]};
  assign status = {chal[63:8], 6'h00, BUSY, LOCKED};
  assign crc_ca = swl_pkg::crc8_byte(swl_pkg::crc8_byte(swl_pkg::CRC_INIT, cmd), nb);
  assign cmd_ev = state == S_FUNC && slot_ev && last && !rst_ev;
  assign BUS.dev_out = 1'b0;

  always_comb begin
    case (state)
      S_MATCH, S_CHAL, S_IDTX: last = bitcnt == 7'd63;
      S_TX: last = bitcnt == 7'd79;
      default: last = bitcnt == 7'd7;
    endcase
  end

  // slot timing counts from each falling edge of the line, the slave's own presence pulse included
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dq_prev <= 1'b1;
      cnt <= CNT_MAX;
    end else if (CE) begin
      dq_prev <= BUS.line;
      if (fall) begin
        cnt <= 12'h000;
      end else if (cnt != CNT_MAX) begin
        cnt <= cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_IDLE;
      pcnt <= 12'h000;
      wait_rise <= 1'b0;
      sr <= '0;
      bitcnt <= 7'd0;
      mismatch <= 1'b0;
      cmd <= 8'h00;
      chal <= 64'h0000_0000_0000_0000;
      SELECTED <= 1'b0;
    end else if (CE) begin
      if (rst_ev) begin
        state <= S_PRES;
        wait_rise <= 1'b1;
        pcnt <= 12'h000;
        SELECTED <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            state <= S_IDLE;
          end
          S_PRES: begin
            if (wait_rise) begin
              wait_rise <= ~BUS.line;
            end else if (pcnt == PE_C) begin
              state <= S_ROM;
              bitcnt <= 7'd0;
            end else begin
              pcnt <= pcnt + 12'h001;
            end
          end
          S_ROM, S_MATCH, S_FUNC, S_CHAL, S_ADDR: begin
            if (slot_ev) begin
              sr <= {BUS.line, sr[79:1]};
              bitcnt <= last ? 7'd0 : bitcnt + 7'd1;
              if (state == S_MATCH && BUS.line != NODE_ID[bitcnt[5:0]]) begin
                mismatch <= 1'b1;
              end
              if (last) begin
                case (state)
                  S_ROM: begin
                    mismatch <= 1'b0;
                    if (nb == swl_pkg::CMD_READ_ID) begin
                      state <= S_IDTX;
                      sr <= {16'h0000, NODE_ID};
                    end else if (nb == swl_pkg::CMD_MATCH) begin
                      state <= S_MATCH;
                    end else if (nb == swl_pkg::CMD_SKIP) begin
                      state <= S_FUNC;
                      SELECTED <= 1'b1;
                    end else begin
                      state <= S_IDLE;
                    end
                  end
                  S_MATCH: begin
                    if (!mismatch && BUS.line == NODE_ID[63]) begin
                      state <= S_FUNC;
                      SELECTED <= 1'b1;
                    end else begin
                      state <= S_IDLE;
                    end
                  end
                  S_FUNC: begin
                    cmd <= nb;
                    if (nb == swl_pkg::CMD_WR_CHAL) begin
                      state <= S_CHAL;
                    end else if (nb == swl_pkg::CMD_READ_STAT) begin
                      state <= S_ADDR;
                    end else begin
                      state <= S_FUNC;
                    end
                  end
                  S_CHAL: begin
                    chal <= nw;
                    state <= S_FUNC;
                  end
                  default: begin
                    // no crc is checked here; the master judges all of them
                    sr <= {crc_over(status, 8), status, crc_ca};
                    state <= S_TX;
                  end
                endcase
              end
            end
          end
          S_IDTX, S_TX: begin
            if (slot_ev) begin
              sr <= {1'b0, sr[79:1]};
              bitcnt <= last ? 7'd0 : bitcnt + 7'd1;
              if (last) begin
                state <= (state == S_IDTX) ? S_FUNC : S_IDLE;
                SELECTED <= state == S_IDTX;
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // the slave only stretches lows the master starts, or answers a reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BUS.dev_oe <= 1'b0;
    end else if (CE) begin
      if (rst_ev) begin
        BUS.dev_oe <= 1'b0;
      end else if (state == S_PRES && !wait_rise && pcnt == PW_C) begin
        BUS.dev_oe <= 1'b1;
      end else if (state == S_PRES && pcnt == PE_C) begin
        BUS.dev_oe <= 1'b0;
      end else if (fall && (state == S_IDTX || state == S_TX) && !sr[0]) begin
        BUS.dev_oe <= 1'b1;
      end else if (cnt == HOLD_C && state != S_PRES) begin
        BUS.dev_oe <= 1'b0;
      end
    end
  end

  // runs on even after a bus reset: the nonvolatile write must finish
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      nv <= N_IDLE;
      tmr <= 20'h00000;
      pend <= swl_pkg::SECRET_RST;
      pend_lock <= 1'b0;
      SECRET <= swl_pkg::SECRET_RST;
      LOCKED <= swl_pkg::LOCK_RST;
      BUSY <= 1'b0;
    end else if (CE) begin
      case (nv)
        N_IDLE: begin
          if (cmd_ev && SELECTED) begin
            pend_lock <= 1'b0;
            if (nb == swl_pkg::CMD_CLEAR) begin
              nv <= N_WRITE;
              tmr <= EE_T;
              pend <= 64'h0000_0000_0000_0000;
              BUSY <= 1'b1;
            end else if (nb == swl_pkg::CMD_NEXT) begin
              nv <= N_HASH;
              tmr <= HASH_T;
              pend <= mix(SECRET, 64'hFFFF_FFFF_FFFF_FFFF, chal);
              BUSY <= 1'b1;
            end else if (nb == swl_pkg::CMD_NEXT_ID) begin
              nv <= N_HASH;
              tmr <= HASH_T;
              pend <= mix(SECRET, NODE_ID, chal);
              BUSY <= 1'b1;
            end else if (nb == swl_pkg::CMD_LOCK) begin
              nv <= N_WRITE;
              tmr <= EE_T;
              pend <= SECRET;
              pend_lock <= 1'b1;
              BUSY <= 1'b1;
            end
          end
        end
        N_HASH: begin
          if (tmr == 20'h00000) begin
            nv <= N_WRITE;
            tmr <= EE_T;
          end else begin
            tmr <= tmr - 20'h00001;
          end
        end
        N_WRITE: begin
          if (tmr == 20'h00000) begin
            nv <= N_IDLE;
            BUSY <= 1'b0;
            if (!LOCKED) begin
              SECRET <= pend;
            end
            if (pend_lock) begin
              LOCKED <= 1'b1;
            end
          end else begin
            tmr <= tmr - 20'h00001;
          end
        end
        default: begin
          nv <= N_IDLE;
        end
      endcase
    end
  end
endmodule

// [testbench/swl_properties.sv]
`timescale 1ns/1ps
module swl_properties (
  input wire logic CLOCK, // clock
  input wire logic RST_N, // reset, low
  input wire logic host_out, // master level
  input wire logic host_oe, // master pulls
  input wire logic dev_out, // slave level
  input wire logic dev_oe, // slave pulls
  input wire logic line // resolved wire
);
  int host_low;
  int dev_low;
  int host_idle;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) host_low <= 0;
    else host_low <= host_oe ? host_low + 1 : 0;
  end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) dev_low <= 0;
    else dev_low <= dev_oe ? dev_low + 1 : 0;
  end
  // saturates so a long idle never wraps
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) host_idle <= 0;
    else host_idle <= host_oe ? 0 : (host_idle < 9999 ? host_idle + 1 : host_idle);
  end
  AST_HOST_OPEN_DRAIN:
    assert property (host_out == 1'b0) else $error("master drives high");
  AST_DEV_OPEN_DRAIN:
    assert property (dev_out == 1'b0) else $error("slave drives high");
  AST_DEV_NO_INITIATE:
    assert property ($rose(dev_oe) |-> host_idle <= swl_pkg::PRES_WAIT_CYC + 2)
    else $error("slave pulled line unprompted");
  AST_PRESENCE_AFTER_RESET:
    assert property ($fell(host_oe) && host_low > swl_pkg::LOW_RESET_CYC |-> ##[1:700] dev_oe)
    else $error("no presence after reset pulse");
  AST_PRESENCE_LEN:
    assert property (dev_low <= swl_pkg::PRES_LEN_CYC + 1) else $error("slave low too long");
  AST_LOW_IS_SLOT_OR_RESET:
    assert property ($fell(host_oe) |-> host_low <= swl_pkg::W0_LOW_CYC + 2
      || host_low > swl_pkg::LOW_RESET_CYC) else $error("ambiguous low width");
  AST_QUIET_IN_RESET_PULSE:
    assert property (host_low > swl_pkg::W0_LOW_CYC + 2 |-> !dev_oe)
    else $error("slave drives during reset pulse");
  AST_IDLE_AFTER_RESET:
    assert property ($rose(RST_N) |-> line && !host_oe) else $error("line not idle");
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int EE = 20;
  localparam int HS = 20;
  logic clock, rst_n, req_valid, req_ready, resp_valid, m_busy, locked, s_busy, selected;
  logic [2:0] req_kind;
  logic [7:0] req_data, resp_data, crc_acc, last_resp;
  logic [63:0] secret, sec_a;
  logic [15:0] rnd, seed;
  logic full_seen;
  int n_mismatch, cmp_count, n_resp, h_len, d_len, d_w, b_len, b_w, t0;
  int hw[$];
  swl_if bus_if();
  swl_master #(.EE_CYC(EE), .HASH_CYC(HS)) swl_master_i (
    .CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_KIND(req_kind), .REQ_DATA(req_data), .RESP_VALID(resp_valid),
    .RESP_DATA(resp_data), .CRC_ACC(crc_acc), .BUSY(m_busy), .BUS(bus_if));
  swl_slave #(.EE_CYC(EE), .HASH_CYC(HS)) swl_slave_i (.CLOCK(clock), .RST_N(rst_n),
    .CE(1'b1), .BUS(bus_if), .SECRET(secret), .LOCKED(locked), .BUSY(s_busy),
    .SELECTED(selected));
  swl_properties swl_properties_i (.CLOCK(clock), .RST_N(rst_n), .host_out(bus_if.host_out),
    .host_oe(bus_if.host_oe), .dev_out(bus_if.dev_out), .dev_oe(bus_if.dev_oe),
    .line(bus_if.line));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // pulse widths on the wire and busy length, measured here, not read from the design
  always @(posedge clock) begin
    if (resp_valid === 1'b1) n_resp <= n_resp + 1;
    if (resp_valid === 1'b1) last_resp <= resp_data;
    if (req_valid && req_ready === 1'b0) full_seen <= 1'b1;
    if (bus_if.host_oe === 1'b1) h_len <= h_len + 1;
    else if (h_len != 0) begin
      hw.push_back(h_len);
      h_len <= 0;
    end
    if (bus_if.dev_oe === 1'b1) d_len <= d_len + 1;
    else if (d_len != 0) begin
      d_w <= d_len;
      d_len <= 0;
    end
    if (s_busy === 1'b1) b_len <= b_len + 1;
    else if (b_len != 0) begin
      b_w <= b_len;
      b_len <= 0;
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic send(input swl_pkg::op_t kind, input logic [7:0] d);
    int i;
    @(posedge clock);
    req_valid <= 1'b1;
    req_kind <= kind;
    req_data <= d;
    for (i = 0; i < 100; i++) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    if (i == 100) timeout();
  endtask
  task automatic wait_resp(input int target);
    int i;
    for (i = 0; i < 100000; i++) begin
      @(posedge clock);
      if (n_resp >= target) break;
    end
    if (i == 100000) timeout();
  endtask
  task automatic run(input swl_pkg::op_t kind, input logic [7:0] d);
    int t;
    t = n_resp + 1;
    send(kind, d);
    wait_resp(t);
  endtask
  // short low means a one, long low a zero
  task automatic wr(input logic [7:0] b);
    logic [7:0] got;
    hw.delete();
    run(swl_pkg::OP_WRITE, b);
    for (int i = 0; i < 8; i++) begin
      got[i] = hw[i] < (swl_pkg::W1_LOW_CYC + swl_pkg::W0_LOW_CYC) / 2;
    end
    check(hw.size(), 8);
    check(got, b);
  endtask
  // shift-register form of x^8+x^5+x^4+1, bits in lsb first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c = {fb, c[7:5], c[4] ^ fb, c[3] ^ fb, c[2:1]};
    end
    return c;
  endfunction
  task automatic chal(input logic [15:0] s);
    wr(swl_pkg::CMD_WR_CHAL);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      wr(s[7:0]);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    {rst_n, req_valid, full_seen} = 3'b000;
    req_kind = swl_pkg::OP_RESET;
    req_data = 8'h00;
    {n_mismatch, cmp_count, n_resp, h_len, d_len, d_w, b_len, b_w} = '0;
    rnd = 16'hAAAC;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    run(swl_pkg::OP_RESET, 8'h00);
    check(selected, 1'b0);
    check(last_resp[0], 1'b1);
    check(d_w, swl_pkg::PRES_LEN_CYC);
    // fill the request buffer behind a slow wait, then drain it
    t0 = n_resp;
    send(swl_pkg::OP_WAIT_EE, rnd[7:0]);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      send(swl_pkg::OP_CRC_CLR, rnd[7:0]);
    end
    wait_resp(t0 + 4);
    check(full_seen, 1'b1);
    check(last_resp, 8'h00);
    check(crc_acc, 8'h00);
    wr(swl_pkg::CMD_SKIP);
    check(selected, 1'b1);
    seed = lfsr(rnd);
    chal(seed);
    wr(swl_pkg::CMD_NEXT);
    run(swl_pkg::OP_WAIT_HASH, rnd[15:8]);
    check(b_w, HS + EE);
    sec_a = secret;
    check(sec_a != 64'h0, 1'b1);
    wr(swl_pkg::CMD_CLEAR);
    run(swl_pkg::OP_WAIT_EE, 8'h00);
    check(b_w, EE);
    check(secret, 64'h0);
    // same secret and challenge: only the identifier term differs
    chal(seed);
    wr(swl_pkg::CMD_NEXT_ID);
    run(swl_pkg::OP_WAIT_HASH, 8'h00);
    check(secret != sec_a && secret != 64'h0, 1'b1);
    sec_a = secret;
    wr(swl_pkg::CMD_LOCK);
    run(swl_pkg::OP_WAIT_EE, 8'h00);
    check(locked, 1'b1);
    check(secret, sec_a);
    chal(lfsr(seed));
    wr(swl_pkg::CMD_NEXT);
    run(swl_pkg::OP_WAIT_HASH, 8'h00);
    check(b_w, HS + EE);
    check(secret, sec_a);
    // status block: its own crc byte must bring the running crc back to zero
    rnd = lfsr(lfsr(seed));
    wr(swl_pkg::CMD_READ_STAT);
    wr(rnd[7:0]);
    run(swl_pkg::OP_READ, rnd[15:8]);
    check(last_resp, crc_step(crc_step(8'h00, swl_pkg::CMD_READ_STAT), rnd[7:0]));
    run(swl_pkg::OP_CRC_CLR, 8'h00);
    for (int i = 0; i < 9; i++) begin
      run(swl_pkg::OP_READ, 8'hFF);
      if (i == 0) check(last_resp, 8'h01);
    end
    check(crc_acc, 8'h00);
    check(m_busy, 1'b0);
    report_and_stop();
  end
endmodule
